// ==== logic/range_tc_pkg.sv ====
package range_tc_pkg;
    localparam logic [5:0] addr_range = 6'h01;
    localparam logic [5:0] addr_tc_one = 6'h02;
    localparam logic [5:0] addr_tc_two = 6'h03;
    localparam logic [5:0] addr_last = 6'h3F;
    localparam logic [7:0] range_reset = 8'h07;
    localparam logic [7:0] tc_one_reset = 8'h90;
    localparam logic [7:0] tc_two_reset = 8'hA0;
    localparam int upper_disable_bit = 7;
    localparam int upper_sel_lo = 4;
    localparam int lower_sel_lo = 0;
    localparam int cap_one_lo = 6;
    localparam int res_one_lo = 0;
    localparam logic [4:0] frame_bits = 5'h10;

    typedef struct packed {
        logic upper_drive_disable;
        logic [2:0] upper_range_select;
        logic [2:0] lower_range_select;
        logic [1:0] first_time_constant_cap;
        logic [4:0] first_time_constant_res;
        logic [7:0] time_constant_two;
    } analog_cfg_t;
endpackage : range_tc_pkg

// ==== logic/sensor_range_timeconst_regs.sv ====
`timescale 1ns/10ps
module sensor_range_timeconst_regs
    import range_tc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic csn, // spi chip select, active low
    input wire logic sclk, // spi clock, sampled
    input wire logic mosi, // spi data in
    output logic miso, // spi data out, registered
    output logic miso_oe_n, // low while miso is driven
    output analog_cfg_t cfg // analog control codes
);
    logic [7:0] range_r, range_nxt;
    logic [7:0] tc1_r, tc1_nxt;
    logic [7:0] tc2_r, tc2_nxt;
    logic sclk_d_r, sclk_d_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [5:0] addr_r, addr_nxt;
    logic rd_r, rd_nxt;
    logic miso_r, miso_nxt;
    logic rise, fall;
    logic [7:0] rd_word; // stored value of the register being read
    logic [7:0] wr_byte; // byte completed by the current rising edge
    logic [4:0] fall_cnt_r, fall_cnt_nxt; // falls seen in this frame, for checking only

    function automatic logic [7:0] read_reg(input logic [5:0] a, input logic [7:0] r0,
                                            input logic [7:0] r1, input logic [7:0] r2);
        unique case (a)
            addr_range: read_reg = r0;
            addr_tc_one: read_reg = r1;
            addr_tc_two: read_reg = r2;
            default: read_reg = 8'h00;
        endcase
    endfunction : read_reg

    assign rise = sclk & ~sclk_d_r;
    assign fall = ~sclk & sclk_d_r;
    // read data is taken from the live register, so a read always sees the latest write
    assign rd_word = read_reg(addr_r, range_r, tc1_r, tc2_r);
    assign wr_byte = {sh_r[6:0], mosi};

    // frame: bit0 r/w (1=read), 7 address bits (top bit dropped), then data bytes
    always_comb begin
        range_nxt = range_r;
        tc1_nxt = tc1_r;
        tc2_nxt = tc2_r;
        sclk_d_nxt = sclk;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        rd_nxt = rd_r;
        miso_nxt = miso_r;
        fall_cnt_nxt = fall_cnt_r;
        if (!csn && fall && fall_cnt_r != 5'h1F) begin
            fall_cnt_nxt = fall_cnt_r + 5'h01;
        end
        if (csn) begin
            fall_cnt_nxt = 5'h00;
            cnt_nxt = 5'h00;
            miso_nxt = 1'b0;
        end else if (rise) begin
            sh_nxt = {sh_r[6:0], mosi};
            if (cnt_r == 5'h07) begin
                rd_nxt = sh_r[6];
                addr_nxt = {sh_r[4:0], mosi};
            end
            // write lands only on the 16th pulse or later byte ends
            if (cnt_r == frame_bits - 5'h01 && !rd_r) begin
                unique case (addr_r)
                    addr_range: range_nxt = wr_byte;
                    addr_tc_one: tc1_nxt = wr_byte;
                    addr_tc_two: tc2_nxt = wr_byte;
                    default: ;
                endcase
            end
            if (cnt_r == frame_bits - 5'h01) begin
                cnt_nxt = 5'h08;
                // extended transfer steps address, capped at the top
                if (addr_r != addr_last) begin
                    addr_nxt = addr_r + 6'h01;
                end
            end else begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end else if (fall && cnt_r >= 5'h08 && rd_r) begin
            // msb first: count 8 gives bit 7, count 15 gives bit 0
            miso_nxt = rd_word[3'(5'h0F - cnt_r)];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            range_r <= range_reset;
            tc1_r <= tc1_reset_val();
            tc2_r <= tc_two_reset;
            sclk_d_r <= 1'b0;
            cnt_r <= 5'h00;
            sh_r <= 8'h00;
            addr_r <= 6'h00;
            rd_r <= 1'b0;
            miso_r <= 1'b0;
            fall_cnt_r <= 5'h00;
        end else begin
            range_r <= range_nxt;
            tc1_r <= tc1_nxt;
            tc2_r <= tc2_nxt;
            sclk_d_r <= sclk_d_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            rd_r <= rd_nxt;
            miso_r <= miso_nxt;
            fall_cnt_r <= fall_cnt_nxt;
        end
    end

    function automatic logic [7:0] tc1_reset_val();
        tc1_reset_val = tc_one_reset;
    endfunction : tc1_reset_val

    assign miso = miso_r;
    assign miso_oe_n = csn;
    // lower/upper ordering is not checked here; misprogramming is the host's problem
    assign cfg.upper_drive_disable = range_r[upper_disable_bit];
    assign cfg.upper_range_select = range_r[upper_sel_lo +: 3];
    assign cfg.lower_range_select = range_r[lower_sel_lo +: 3];
    assign cfg.first_time_constant_cap = tc1_r[cap_one_lo +: 2];
    assign cfg.first_time_constant_res = tc1_r[res_one_lo +: 5];
    assign cfg.time_constant_two = tc2_r;

    reset_range_a: assert property (@(posedge clk) !resetn |=> range_r == 8'h07 && tc1_r == 8'h90)
        else $error("bad reset value");
    reset_fields_a: assert property (@(posedge clk) !resetn |=>
        cfg.lower_range_select == 3'h7 && cfg.upper_range_select == 3'h0)
        else $error("bad range field reset");
    reset_cap_a: assert property (@(posedge clk) !resetn |=>
        cfg.first_time_constant_cap == 2'h2 && cfg.first_time_constant_res == 5'h10)
        else $error("bad tc field reset");
    reset_tc2_a: assert property (@(posedge clk) !resetn |=> tc2_r == 8'hA0)
        else $error("bad tc2 reset");
    short_write_a: assert property (@(posedge clk) disable iff (!resetn)
        (csn || cnt_r < 5'h0F || !rise) |=> $stable(range_r) || $past(cnt_r) == 5'h0F)
        else $error("register changed before 16th pulse");
    disable_map_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.upper_drive_disable == range_r[7]) else $error("disable bit miswired");
    upper_map_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.upper_range_select == range_r[6:4]) else $error("upper select miswired");
    cap_map_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.first_time_constant_cap == tc1_r[7:6]) else $error("cap miswired");
    idle_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
        csn |=> !miso) else $error("miso active while deselected");

    // the checks below tie the field outputs and the write path to the stored bytes;
    // a miswired field or a write landing early would otherwise only show up in the
    // analog front end, long after the frame that caused it
    lower_map_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.lower_range_select == range_r[2:0]) else $error("lower select miswired");
    res_map_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.first_time_constant_res == tc1_r[4:0]) else $error("res miswired");
    tc2_map_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg.time_constant_two == tc2_r) else $error("tc2 miswired");
    oe_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        miso_oe_n == csn) else $error("miso enable not following select");

    // a completed write frame must leave exactly the shifted byte in the addressed register
    range_write_a: assert property (@(posedge clk) disable iff (!resetn)
        (!csn && rise && cnt_r == 5'h0F && !rd_r && addr_r == addr_range) |=>
        range_r == $past(wr_byte)) else $error("range write lost");
    tc1_write_a: assert property (@(posedge clk) disable iff (!resetn)
        (!csn && rise && cnt_r == 5'h0F && !rd_r && addr_r == addr_tc_one) |=>
        tc1_r == $past(wr_byte)) else $error("tc1 write lost");
    tc2_write_a: assert property (@(posedge clk) disable iff (!resetn)
        (!csn && rise && cnt_r == 5'h0F && !rd_r && addr_r == addr_tc_two) |=>
        tc2_r == $past(wr_byte)) else $error("tc2 write lost");

    // a read frame must never disturb the stored values
    read_keeps_a: assert property (@(posedge clk) disable iff (!resetn)
        (!csn && rd_r) |=> $stable(range_r) && $stable(tc1_r) && $stable(tc2_r))
        else $error("read frame altered a register");

    // deselect aborts a frame: the bit count restarts so a short frame cannot
    // be completed by pulses of the next one
    frame_abort_a: assert property (@(posedge clk) disable iff (!resetn)
        csn |=> cnt_r == 5'h00) else $error("bit count kept across frames");
    count_bound_a: assert property (@(posedge clk) disable iff (!resetn)
        cnt_r <= 5'h0F) else $error("bit count out of range");

    // during the data byte of a read, the line carries the stored bit for this count;
    // the registered output lags the detected fall by one clock
    read_bit_a: assert property (@(posedge clk) disable iff (!resetn)
        (!csn && fall && rd_r && cnt_r >= 5'h08) |=>
        miso == $past(rd_word[3'(5'h0F - cnt_r)])) else $error("read bit wrong");

    // until the first falling edge of a frame, with no bit counted yet, miso must stay low
    early_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
        (!csn && fall_cnt_r == 5'h00 && cnt_r == 5'h00) |=> !miso)
        else $error("miso driven before command done");
endmodule : sensor_range_timeconst_regs

// ==== verif/spi_host_model.sv ====
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clk, // system clock
    output logic csn, // chip select, active low
    output logic sclk, // serial clock, idles low
    output logic mosi, // data to device
    input wire logic miso // data from device
);
    initial begin
        csn = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    // 4 clk phases leave margin over the 2 clk minimum; n < 16 makes a short frame
    task automatic frame(input logic rw, input logic [5:0] a, input logic [7:0] wd,
                         input int n, output logic [7:0] rdat);
        logic [15:0] sh;
        sh = {rw, 1'b0, a, wd};
        rdat = 8'h00;
        @(posedge clk) csn <= 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi <= sh[15 - i];
            repeat (4) @(posedge clk);
            if (i >= 8) rdat[15 - i] = miso;
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        csn <= 1'b1;
        // released data line must not keep its last value
        mosi <= ~mosi;
        repeat (3) @(posedge clk);
    endtask : frame
endmodule : spi_host_model

// ==== verif/test_sensor_range_timeconst_regs.sv ====
`timescale 1ns/10ps
module test_sensor_range_timeconst_regs;
    import range_tc_pkg::*;
    logic clk, resetn, csn, sclk, mosi, miso, miso_oe_n;
    analog_cfg_t cfg;
    int bad_count = 0;
    int total_checks = 0;
    logic [7:0] mdl [1:3];
    logic [7:0] lfsr = 8'h1B;
    logic [7:0] rd, v;
    sensor_range_timeconst_regs dut (.clk(clk), .resetn(resetn), .csn(csn), .sclk(sclk),
        .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n), .cfg(cfg));
    spi_host_model host (.clk(clk), .csn(csn), .sclk(sclk), .mosi(mosi), .miso(miso));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    task automatic read_all;
        for (int a = 1; a <= 3; a++) begin
            host.frame(1'b1, 6'(a), 8'h00, 16, rd);
            check("reg", 32'(rd), 32'(mdl[a]));
        end
        check("cfg", 32'(cfg), 32'({mdl[1][7:4], mdl[1][2:0], mdl[2][7:6], mdl[2][4:0],
            mdl[3]}));
        check("miso_oe_n", 32'(miso_oe_n), 32'h1);
    endtask : read_all
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        results();
    end
    initial begin
        resetn = 1'b0;
        mdl[1] = 8'h07;
        mdl[2] = 8'h90;
        mdl[3] = 8'hA0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        read_all();
        for (int k = 0; k < 9; k++) begin
            lfsr = lfsr_next(lfsr);
            v = lfsr;
            if (k % 3 == 0) begin
                v[3] = 1'b0;
                if (v[2:0] < v[6:4]) v[2:0] = v[6:4];
            end
            if (k % 3 == 1) v[5] = 1'b0;
            host.frame(1'b0, 6'(k % 3 + 1), v, 16, rd);
            mdl[k % 3 + 1] = v;
            read_all();
        end
        host.frame(1'b0, 6'h02, 8'h3C, 12, rd);
        read_all();
        host.frame(1'b1, 6'h05, 8'h00, 16, rd);
        check("unmapped", 32'(rd), 32'h0);
        results();
    end
endmodule : test_sensor_range_timeconst_regs
